// ==== kwu_key_wakeup.sv ====
// Purpose: Key-on wakeup and standby-stop release control with AHB-Lite registers
// Assumes: Pins synchronous to hclk; warm-up itself is done by the standby controller
//          Bus always answers OKAY with no wait states
// Notes:   Wake request is also formed as a pure combinational level for clockless use
//          Key-wake lows release in both modes; edge mode needs hclk to see the edge
//          Enable bits are write-only, so software keeps its own copy
module kwu_key_wakeup #(
   parameter int NUM_KEYS = 4
) (
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   input  wire  logic        standby_release_pin,
   input  wire  logic        key_wake_pin_a,
   input  wire  logic        key_wake_pin_b,
   input  wire  logic        key_wake_pin_c,
   input  wire  logic        key_wake_pin_d,
   output logic              stop_mode,
   output logic              release_start,
   output logic              wake_request
);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   // Pin list below is fixed at four
   if (NUM_KEYS != 4) begin : g_bad_keys
      $error("kwu_key_wakeup serves exactly four key-wake pins");
   end

   // Enables must stay inside the byte-wide register
   if (kwu_pkg::KWU_EN_LSB + NUM_KEYS > kwu_pkg::KWU_SC_STOP_BIT + 1) begin : g_bad_en_field
      $error("kwu_key_wakeup enable field overflows the register byte");
   end

   // Register index slice must fit inside the address bus
   if (kwu_pkg::KWU_IDX_LSB + $bits(kwu_pkg::KWU_IDX_STATUS) > $bits(haddr)) begin : g_bad_idx
      $error("kwu_key_wakeup register index does not fit the address");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   // All state in one packed register
   typedef struct packed {
      kwu_pkg::kwu_aphase_s  aph;
      logic [NUM_KEYS-1:0]   key_en;
      logic                  relm;
      kwu_pkg::kwu_mode_e    mode;
      logic                  rel_pin_prev;
      logic                  rel_pulse;
      logic                  skipped;
      logic [31:0]           rdata;
   } kwu_state_s;

   kwu_state_s s_q;
   kwu_state_s s_d;

   logic [NUM_KEYS-1:0] key_pins;
   logic                key_wake_lvl;
   logic                pin_wake_lvl;
   logic                rel_edge;
   logic                stop_req;
   logic                wr_hit_en;
   logic                wr_hit_sc;
   logic [11:0]         rd_idx;

   // Dedicated detector path, never the port data register
   assign key_pins = {key_wake_pin_d, key_wake_pin_c, key_wake_pin_b, key_wake_pin_a};

   // Address-phase register index
   assign rd_idx = haddr[kwu_pkg::KWU_IDX_LSB +: $bits(rd_idx)];

   // Any enabled key pulled low
   function automatic logic kwu_key_low(input logic [NUM_KEYS-1:0] pins,
                                         input logic [NUM_KEYS-1:0] en);
      kwu_key_low = |(en & ~pins);
   endfunction

   // Address decode shared by read and write paths
   function automatic logic kwu_hit(input logic [11:0] idx,
                                     input logic [11:0] target);
      kwu_hit = (idx == target);
   endfunction

   // ----------------------------------------
   // Clockless wake combination
   // ----------------------------------------
   // Level terms only, so this still works with the main clock stopped
   assign key_wake_lvl = kwu_key_low(key_pins, s_q.key_en);
   assign pin_wake_lvl = s_q.relm & standby_release_pin;
   assign wake_request = key_wake_lvl | pin_wake_lvl;

   // Edge mode needs the clock; the controller restarts it only after release
   assign rel_edge = ~s_q.relm & standby_release_pin & ~s_q.rel_pin_prev;

   // ----------------------------------------
   // Bus data-phase decode
   // ----------------------------------------
   // Writes land in the data phase, while hwdata stands
   assign wr_hit_en = s_q.aph.valid & s_q.aph.write
                    & kwu_hit(s_q.aph.idx, kwu_pkg::KWU_IDX_KEY_WAKE_ENABLE);
   assign wr_hit_sc = s_q.aph.valid & s_q.aph.write
                    & kwu_hit(s_q.aph.idx, kwu_pkg::KWU_IDX_SYSTEM_CONTROL_ONE);
   assign stop_req  = wr_hit_sc & hwdata[kwu_pkg::KWU_SC_STOP_BIT];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d              = s_q;
      s_d.rel_pin_prev = standby_release_pin;
      s_d.rel_pulse    = 1'b0;

      // Address phase capture
      s_d.aph.valid = hsel & hready
                    & (htrans == kwu_pkg::KWU_HTRANS_NONSEQ
                       || htrans == kwu_pkg::KWU_HTRANS_SEQ);
      s_d.aph.write = hwrite;
      s_d.aph.idx   = rd_idx;

      // Read data prepared at the address phase; IDLE cycles leave it at zero
      s_d.rdata = '0;
      if (s_d.aph.valid & ~hwrite) begin
         if (kwu_hit(rd_idx, kwu_pkg::KWU_IDX_KEY_WAKE_ENABLE)) begin
            s_d.rdata = '0;
         end else if (kwu_hit(rd_idx, kwu_pkg::KWU_IDX_SYSTEM_CONTROL_ONE)) begin
            s_d.rdata[kwu_pkg::KWU_SC_RELM_BIT] = s_q.relm;
         end else if (kwu_hit(rd_idx, kwu_pkg::KWU_IDX_STATUS)) begin
            s_d.rdata[kwu_pkg::KWU_ST_STOP_BIT] = (s_q.mode == kwu_pkg::KWU_STOP);
            s_d.rdata[kwu_pkg::KWU_ST_WAKE_BIT] = wake_request;
            s_d.rdata[kwu_pkg::KWU_ST_RELM_BIT] = s_q.relm;
            s_d.rdata[kwu_pkg::KWU_ST_SKIP_BIT] = s_q.skipped;
         end
      end

      // Register writes in the data phase
      if (wr_hit_en) begin
         s_d.key_en = hwdata[kwu_pkg::KWU_EN_LSB +: NUM_KEYS];
      end
      if (wr_hit_sc) begin
         s_d.relm = hwdata[kwu_pkg::KWU_SC_RELM_BIT];
      end

      unique case (s_q.mode)
         kwu_pkg::KWU_RUN: begin
            if (stop_req) begin
               // Release condition already present: go straight to warm-up
               if (standby_release_pin
                   || kwu_key_low(key_pins, s_q.key_en)) begin
                  s_d.rel_pulse = 1'b1;
                  s_d.skipped   = 1'b1;
               end else begin
                  // Nothing pending: enter stop
                  s_d.mode    = kwu_pkg::KWU_STOP;
                  s_d.skipped = 1'b0;
               end
            end
         end
         kwu_pkg::KWU_STOP: begin
            // A further stop write is ignored here
            if (wake_request | rel_edge) begin
               s_d.mode      = kwu_pkg::KWU_RUN;
               s_d.rel_pulse = 1'b1;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q.aph          <= '0;
         // Enables reset to disabled, so no key pin wakes the part unasked
         s_q.key_en       <= '0;
         s_q.relm         <= kwu_pkg::KWU_RELM_RESET;
         s_q.mode         <= kwu_pkg::KWU_RUN;
         // Release pin idles low, so no false edge follows reset
         s_q.rel_pin_prev <= 1'b0;
         s_q.rel_pulse    <= 1'b0;
         s_q.skipped      <= 1'b0;
         s_q.rdata        <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // No wait states and no error responses
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   // Data output straight from the flop
   assign hrdata        = s_q.rdata;
   assign stop_mode     = (s_q.mode == kwu_pkg::KWU_STOP);
   assign release_start = s_q.rel_pulse;

endmodule

// ==== kwu_key_wakeup_bench.sv ====
// Purpose: Self-checking bench for the key wakeup block
// Assumes: Zero-wait slave, hready tied to hreadyout
// Notes:   Read data checked against a queue of expected words
module kwu_key_wakeup_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, standby_release_pin = 0, rd_dp = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, exp_q[$];
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [3:0] press = '0;
   logic hready, hreadyout, hresp, stop_mode, release_start, wake_request;
   logic key_wake_pin_a, key_wake_pin_b, key_wake_pin_c, key_wake_pin_d;
   int fails = 0, n_compared = 0, seed = 86, k;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   kwu_key_wakeup dut (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .hsel                (hsel),
      .haddr               (haddr),
      .htrans              (htrans),
      .hwrite              (hwrite),
      .hsize               (hsize),
      .hwdata              (hwdata),
      .hready              (hready),
      .hreadyout           (hreadyout),
      .hrdata              (hrdata),
      .hresp               (hresp),
      .standby_release_pin (standby_release_pin),
      .key_wake_pin_a      (key_wake_pin_a),
      .key_wake_pin_b      (key_wake_pin_b),
      .key_wake_pin_c      (key_wake_pin_c),
      .key_wake_pin_d      (key_wake_pin_d),
      .stop_mode           (stop_mode),
      .release_start       (release_start),
      .wake_request        (wake_request)
   );
   kwu_keys u_keys (
      .press          (press),
      .key_wake_pin_a (key_wake_pin_a),
      .key_wake_pin_b (key_wake_pin_b),
      .key_wake_pin_c (key_wake_pin_c),
      .key_wake_pin_d (key_wake_pin_d)
   );
   task automatic chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= kwu_pkg::KWU_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask
   task rd(input logic [31:0] a, e);
      exp_q.push_back(e);
      bus(1'b0, a, '0);
   endtask
   task wrel;
      // Step off the edge so a pulse launched there is seen
      #1;
      for (int i = 0; i < 20 && release_start !== 1'b1; i++) begin
         @(posedge hclk);
         #1;
      end
      chk(release_start, 1);
      chk(stop_mode, 0);
   endtask
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Data phase sampled mid-cycle, clear of the register update
   always @(posedge hclk) rd_dp <= hsel && htrans[1] && !hwrite;
   always @(negedge hclk) if (rd_dp) chk(hrdata, exp_q.pop_front());
   initial begin
      #20000;
      fails++;
      print_verdict;
   end
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b1, 32'h0000_00C4, 32'h0000_00F0);
      rd(32'h0000_00C4, '0);
      rd(32'h0000_0100, '0);
      for (k = 0; k < 4; k++) begin
         bus(1'b1, 32'h0000_00E0, 32'h0000_0084);
         rd(32'h0000_00E4, 32'h0000_0005);
         @(posedge hclk) press <= 4'h1 << k;
         wrel;
         chk(wake_request, 1);
         @(posedge hclk) press <= '0;
      end
      @(posedge hclk) press <= 4'h1 << k[1:0];
      bus(1'b1, 32'h0000_00E0, 32'h0000_0084);
      wrel;
      rd(32'h0000_00E4, 32'h0000_000E);
      k = $unsigned($random(seed)) % 4;
      bus(1'b1, 32'h0000_00C4, {24'h0, 4'hF ^ (4'h1 << k), 4'h0});
      @(posedge hclk) press <= 4'h1 << k;
      bus(1'b1, 32'h0000_00E0, 32'h0000_0084);
      rd(32'h0000_00E4, 32'h0000_0005);
      @(posedge hclk) standby_release_pin <= 1'b1;
      wrel;
      rd(32'h0000_00E4, 32'h0000_0006);
      @(posedge hclk) standby_release_pin <= 1'b0;
      press <= '0;
      bus(1'b1, 32'h0000_00E0, 32'h0000_0080);
      rd(32'h0000_00E4, 32'h0000_0001);
      @(posedge hclk) standby_release_pin <= 1'b1;
      wrel;
      rd(32'h0000_00E4, '0);
      print_verdict;
   end
endmodule

// ==== kwu_key_wakeup_sva.sv ====
// Purpose: Port checker for the key wakeup block
// Assumes: One hclk domain; hready follows hreadyout
// Notes:   Helper flops mark bus data phases
module kwu_key_wakeup_sva #(
   parameter int NUM_KEYS = 4
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        standby_release_pin,
   input wire logic        stop_mode,
   input wire logic        release_start,
   input wire logic        wake_request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_en_q;
   logic sc_wr_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_en_q <= 1'b0;
         sc_wr_q <= 1'b0;
      end else begin
         rd_en_q <= hsel && htrans[1] && !hwrite && haddr[13:2] == 12'h031;
         sc_wr_q <= hsel && htrans[1] && hwrite && haddr[13:2] == 12'h038;
      end
   end
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
   a_enable_wo: assert property (rd_en_q |-> hrdata == '0) else $error("enable readback");
   a_key_release: assert property (stop_mode && wake_request |=> !stop_mode && release_start)
      else $error("no release");
   a_pulse_one: assert property (release_start |=> !release_start) else $error("long pulse");
   a_exit_pulse: assert property ($fell(stop_mode) |-> release_start) else $error("silent exit");
   a_stop_entry: assert property ($rose(stop_mode) |-> $past(sc_wr_q) && $past(hwdata[7]))
      else $error("stop without write");
   a_stop_skip: assert property (sc_wr_q && hwdata[7] && wake_request |=> !stop_mode)
      else $error("stop not skipped");
   a_stop_hold: assert property (stop_mode && !wake_request && !standby_release_pin
      && !$past(standby_release_pin) |=> stop_mode) else $error("spurious exit");
   c_key: cover property (stop_mode && wake_request);
   c_skip: cover property (sc_wr_q && hwdata[7] && wake_request);
   c_edge: cover property (stop_mode ##1 $rose(standby_release_pin));
endmodule

bind kwu_key_wakeup kwu_key_wakeup_sva #(.NUM_KEYS(NUM_KEYS)) u_sva (
   .hclk                (hclk),
   .hresetn             (hresetn),
   .hsel                (hsel),
   .haddr               (haddr),
   .htrans              (htrans),
   .hwrite              (hwrite),
   .hwdata              (hwdata),
   .hreadyout           (hreadyout),
   .hrdata              (hrdata),
   .hresp               (hresp),
   .standby_release_pin (standby_release_pin),
   .stop_mode           (stop_mode),
   .release_start       (release_start),
   .wake_request        (wake_request)
);

// ==== kwu_keys.sv ====
// Purpose: Keys on the four wake pins
// Assumes: Pull-ups hold open keys high
// Notes:   A set press bit closes that key to ground
module kwu_keys (
   input  wire logic [3:0] press,
   output logic            key_wake_pin_a,
   output logic            key_wake_pin_b,
   output logic            key_wake_pin_c,
   output logic            key_wake_pin_d
);
   timeunit 1ns;
   timeprecision 1ps;
   // Open keys idle high, so enabled pins read high before stop
   // Keys drive plain digital inputs of the block, never analog
   assign {key_wake_pin_d, key_wake_pin_c, key_wake_pin_b, key_wake_pin_a} = ~press;
endmodule

// ==== kwu_pkg.sv ====
// Purpose: Shared constants and types of the key-on wakeup block
// Assumes: AHB-Lite register access, 32-bit words, one aligned word per register
// Notes:   Register indices are multiplied by four to form byte addresses
package kwu_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] KWU_IDX_KEY_WAKE_ENABLE    = 12'h0031;
   localparam logic [11:0] KWU_IDX_SYSTEM_CONTROL_ONE = 12'h0038;
   localparam logic [11:0] KWU_IDX_STATUS             = 12'h0039;
   localparam int          KWU_IDX_LSB                = 2;

   // ----------------------------------------
   // Field layout
   // ----------------------------------------
   localparam int          KWU_EN_LSB       = 4;
   localparam int          KWU_SC_RELM_BIT  = 2;
   localparam int          KWU_SC_STOP_BIT  = 7;
   localparam int          KWU_ST_STOP_BIT  = 0;
   localparam int          KWU_ST_WAKE_BIT  = 1;
   localparam int          KWU_ST_RELM_BIT  = 2;
   localparam int          KWU_ST_SKIP_BIT  = 3;
   localparam logic        KWU_RELM_RESET   = 1'b0;
   localparam logic [1:0]  KWU_HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0]  KWU_HTRANS_SEQ    = 2'b11;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic {
      KWU_RUN,
      KWU_STOP
   } kwu_mode_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] idx;
   } kwu_aphase_s;

endpackage
